// File: hw/sef_top.sv
/*
  Serial EEPROM front end: instruction capture, MSB-first shifting,
  pause handling, 1024-byte array and self-timed write cycle.
  Assumes the serial clock is slower than ref_clk by at least 4x.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sef_consts.svh"
module sef_top #(
  parameter int TWC_CYCLES = `SEF_TWC_CYC,
  parameter int MEM_BYTES = `SEF_MEM_BYTES,
  parameter int FIFO_DEPTH = `SEF_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic si,
  output logic so_o,
  output logic so_oe,
  output logic write_in_progress_flag
);
  localparam int AW = $clog2(MEM_BYTES);
  localparam int FW = AW + 8;
  // Refuse geometry the logic cannot serve
  initial begin
    if (MEM_BYTES != 1024) $error("sef_top: array must be 1024 bytes");
    if (TWC_CYCLES < 2) $error("sef_top: TWC_CYCLES too small");
  end

  // Reset release through two flops
  // Release is synchronous, so no flop leaves reset a cycle apart
  logic rs1_q, rst_n;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rs1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rst_n <= rs1_q;
    end
  end

  // Filtered pin levels
  // Four flops per pin; a level moves only when stages agree
  logic sck_s, cs_s, hold_s, si_s;
  sef_sync #(.INIT(1'b0)) u_sck (.clk(ref_clk), .rst_n(rst_n),
    .ce(clk_en), .pin(sck), .level(sck_s));
  sef_sync #(.INIT(1'b1)) u_cs (.clk(ref_clk), .rst_n(rst_n),
    .ce(clk_en), .pin(cs_n), .level(cs_s));
  sef_sync #(.INIT(1'b1)) u_hold (.clk(ref_clk), .rst_n(rst_n),
    .ce(clk_en), .pin(hold_n), .level(hold_s));
  sef_sync #(.INIT(1'b0)) u_si (.clk(ref_clk), .rst_n(rst_n),
    .ce(clk_en), .pin(si), .level(si_s));

  // Shift a bit in at the LSB, MSB arrives first
  function automatic logic [7:0] shift_in(input logic [7:0] v,
                                          input logic b);
    shift_in = {v[6:0], b};
  endfunction : shift_in

  // Status byte as the host sees it, busy in bit 0, latch in bit 1
  function automatic logic [7:0] status_word(input logic [7:0] bp,
                                             input logic wel,
                                             input logic busy);
    status_word = {bp[7:2], wel, busy};
  endfunction : status_word

  // Edge detect state
  // Pause only counts inside a frame; select still acts while paused
  logic sck_prev_q, cs_prev_q;
  logic paused;
  logic sck_rise, sck_fall, cs_rise;
  assign paused = !cs_s && !hold_s;
  assign sck_rise = sck_s && !sck_prev_q && !paused;
  assign sck_fall = !sck_s && sck_prev_q && !paused;
  assign cs_rise = cs_s && !cs_prev_q;

  // Serial engine state
  sef_pkg::sef_phase_t ph_q, ph_d;
  logic [7:0] sh_q, sh_d;  // Input shifter
  logic [2:0] bit_q, bit_d;  // Bits taken in current byte
  logic [7:0] out_q, out_d;  // Output shifter
  logic [AW-1:0] addr_q, addr_d;  // Array pointer
  logic wel_q, wel_d;  // Write enable latch
  logic wr_ok_q, wr_ok_d;  // Last write byte ended on a boundary
  logic drive_q, drive_d;  // Output driven in read phases
  logic [7:0] bp_q, bp_d;  // Writable status bits
  logic push;  // Byte to the write buffer
  logic [FW-1:0] push_data;
  logic fifo_ready;
  logic commit;  // Select rise on a valid write

  // Array and write cycle state
  logic [7:0] mem_q [MEM_BYTES];
  logic busy_q, busy_d;
  logic [31:0] twc_q, twc_d;
  logic f_valid, f_ready;
  logic [FW-1:0] f_data;
  logic f_clr;

  // Serial engine next state
  always_comb begin
    logic [7:0] nb;
    nb = shift_in(sh_q, si_s);
    ph_d = ph_q;
    sh_d = sh_q;
    bit_d = bit_q;
    out_d = out_q;
    addr_d = addr_q;
    wel_d = wel_q;
    wr_ok_d = wr_ok_q;
    drive_d = drive_q;
    bp_d = bp_q;
    push = 1'b0;
    push_data = {addr_q, nb};
    commit = 1'b0;
    if (cs_s) begin
      // Deselected: drop partial byte, wait for instruction
      ph_d = sef_pkg::SEF_CMD;
      bit_d = '0;
      drive_d = 1'b0;
      wr_ok_d = 1'b0;
      if (cs_rise && ph_q == sef_pkg::SEF_WR_DATA && wr_ok_q
          && bit_q == 3'd0) begin
        commit = 1'b1;
        wel_d = 1'b0;
      end
      // Limitation: a long ignored frame ending on a latch-like byte
      // is taken as that latch command
      if (cs_rise && ph_q == sef_pkg::SEF_IGNORE && bit_q == 3'd0) begin
        // Latch ops take effect only on a clean boundary
        if (sh_q == `SEF_OP_LATCH_SET) wel_d = 1'b1;
        if (sh_q == `SEF_OP_LATCH_CLR) wel_d = 1'b0;
      end
    end else if (sck_rise) begin
      // Sample on rising edge, counter survives pauses
      sh_d = nb;
      bit_d = bit_q + 3'd1;
      if (bit_q == 3'd7) begin
        case (ph_q)
          sef_pkg::SEF_CMD: begin
            case (nb)
              `SEF_OP_READ: ph_d = busy_q ? sef_pkg::SEF_IGNORE
                                          : sef_pkg::SEF_ADDR_HI;
              `SEF_OP_WRITE: ph_d = (wel_q && !busy_q)
                ? sef_pkg::SEF_ADDR_HI : sef_pkg::SEF_IGNORE;
              `SEF_OP_STAT_RD: ph_d = sef_pkg::SEF_STAT_OUT;
              `SEF_OP_STAT_WR: ph_d = (wel_q && !busy_q)
                ? sef_pkg::SEF_STAT_IN : sef_pkg::SEF_IGNORE;
              default: ph_d = sef_pkg::SEF_IGNORE;
            endcase
            if (nb == `SEF_OP_STAT_RD) begin
              out_d = status_word(bp_q, wel_q, busy_q);
              drive_d = 1'b1;
            end
            // Shifter keeps the opcode only until the first address bit; out_q carries it to the address phase
            sh_d = nb;
          end
          sef_pkg::SEF_ADDR_HI: begin
            addr_d = {nb[AW-9:0], addr_q[7:0]};
            ph_d = sef_pkg::SEF_ADDR_LO;
          end
          sef_pkg::SEF_ADDR_LO: begin
            addr_d = {addr_q[AW-1:8], nb};
            if (wel_q && out_q == `SEF_OP_WRITE) begin
              ph_d = sef_pkg::SEF_WR_DATA;
            end else begin
              ph_d = sef_pkg::SEF_RD_DATA;
              out_d = mem_q[{addr_q[AW-1:8], nb}];
              drive_d = 1'b1;
            end
          end
          sef_pkg::SEF_RD_DATA: begin
            // Pointer moves once a whole byte has gone out
            addr_d = addr_q + 1'b1;
          end
          sef_pkg::SEF_WR_DATA: begin
            push = fifo_ready;  // Overflow bytes are dropped
            addr_d = addr_q + 1'b1;
            wr_ok_d = 1'b1;
          end
          sef_pkg::SEF_STAT_IN: begin
            bp_d = {nb[7:2], 2'b00};
            wr_ok_d = 1'b0;
            wel_d = 1'b0;
          end
          default: ;
        endcase
      end else if (ph_q == sef_pkg::SEF_WR_DATA) begin
        wr_ok_d = 1'b0;  // Mid-byte: abort on select rise
      end
      // Keep opcode readable for address phase; a status read keeps
      // its status byte in the output shifter instead
      if (ph_q == sef_pkg::SEF_CMD && bit_q == 3'd7
          && nb != `SEF_OP_STAT_RD) out_d = nb;
    end else if (sck_fall && drive_q && bit_q != 3'd0) begin
      // Present next bit after falling edge
      out_d = {out_q[6:0], 1'b0};
    end else if (sck_fall && drive_q && bit_q == 3'd0) begin
      if (ph_q == sef_pkg::SEF_RD_DATA) begin
        // Reload from the pointer; the first reload after the address
        // repeats the byte already loaded, later ones take the next
        out_d = mem_q[addr_q];
      end else if (ph_q == sef_pkg::SEF_STAT_OUT) begin
        // Refreshed each byte so a poll sees busy drop
        out_d = status_word(bp_q, wel_q, busy_q);
      end
    end
  end

  // Serial engine registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_q <= sef_pkg::SEF_CMD;
      sh_q <= '0;
      bit_q <= '0;
      out_q <= '0;
      addr_q <= '0;
      wel_q <= 1'b0;
      wr_ok_q <= 1'b0;
      drive_q <= 1'b0;
      bp_q <= '0;
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else if (clk_en) begin
      ph_q <= ph_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      out_q <= out_d;
      addr_q <= addr_d;
      wel_q <= wel_d;
      wr_ok_q <= wr_ok_d;
      drive_q <= drive_d;
      bp_q <= bp_d;
      sck_prev_q <= paused ? sck_prev_q : sck_s;
      cs_prev_q <= cs_s;
    end
  end

  // Write buffer holds address and data until commit
  sef_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_buf (
    .clk(ref_clk), .rst_n(rst_n), .ce(clk_en), .clr(f_clr),
    .in_valid(push), .in_ready(fifo_ready), .in_data(push_data),
    .out_valid(f_valid), .out_ready(f_ready), .out_data(f_data));

  // Aborted writes flush the buffer
  // Never while busy, or bytes still draining would be lost
  assign f_clr = cs_rise && !commit && !busy_q;
  // Drain one byte per cycle only during the write cycle
  assign f_ready = busy_q;

  // Trade-off: the buffer drains during the timed cycle, so array
  // reads are refused until busy drops
  // Write cycle timer next state
  always_comb begin
    busy_d = busy_q;
    twc_d = twc_q;
    if (commit && !busy_q) begin
      busy_d = 1'b1;
      twc_d = TWC_CYCLES - 1;
    end else if (busy_q) begin
      if (twc_q == 32'h0000_0000) begin
        busy_d = 1'b0;
      end else begin
        twc_d = twc_q - 32'h0000_0001;
      end
    end
  end

  // Timer registers and array update
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      twc_q <= '0;
      for (int i = 0; i < MEM_BYTES; i++) mem_q[i] <= 8'h00;
    end else if (clk_en) begin
      busy_q <= busy_d;
      twc_q <= twc_d;
      if (f_valid && f_ready) mem_q[f_data[FW-1:8]] <= f_data[7:0];
    end
  end

  // Output pin: hi-Z when paused or deselected
  assign so_o = out_q[7];
  assign so_oe = drive_q && !cs_s && hold_s;
  assign write_in_progress_flag = busy_q;
endmodule : sef_top
`default_nettype wire

// File: hw/sef_consts.svh
/*
  Timing counts, opcodes and field positions for the serial EEPROM front end.
  Assumes inclusion by bare name from design files only.
*/
`ifndef SEF_CONSTS_SVH
`define SEF_CONSTS_SVH

// Instruction bytes
`define SEF_OP_READ 8'h03
`define SEF_OP_WRITE 8'h02
`define SEF_OP_LATCH_CLR 8'h04
`define SEF_OP_LATCH_SET 8'h06
`define SEF_OP_STAT_RD 8'h05
`define SEF_OP_STAT_WR 8'h01
// Status bit positions
`define SEF_ST_BUSY 0
`define SEF_ST_WEL 1
// Clock and write cycle timing
`define SEF_CLK_HZ 40000000
`define SEF_TWC_MS 5
// Longest time rounds down
`define SEF_TWC_CYC ((`SEF_CLK_HZ / 1000) * `SEF_TWC_MS)
// Array geometry
`define SEF_MEM_BYTES 1024
`define SEF_FIFO_DEPTH 8

`endif

// File: hw/sef_pkg.sv
/*
  Types shared by the serial EEPROM front end.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sef_pkg;
  // Transaction phases
  typedef enum logic [2:0] {
    SEF_CMD, SEF_ADDR_HI, SEF_ADDR_LO, SEF_RD_DATA, SEF_WR_DATA,
    SEF_STAT_OUT, SEF_STAT_IN, SEF_IGNORE
  } sef_phase_t;
endpackage : sef_pkg

// File: hw/sef_fifo.sv
/*
  Small flip-flop FIFO with valid/ready on both sides.
  Assumes a single clock and a synchronous clear on top of reset.
*/
`timescale 1ns/1ps
`default_nettype none
module sef_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clr,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // Refuse depths the pointer math cannot serve
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("sef_fifo: DEPTH must be a power of two >= 2");
    end
  end
  logic [WIDTH-1:0] mem_q [DEPTH];  // Storage
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW:0] wr_q, wr_d;  // Write pointer with wrap bit
  logic [AW:0] rd_q, rd_d;  // Read pointer with wrap bit
  logic full, empty;

  assign empty = (wr_q == rd_q);
  assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_q[rd_q[AW-1:0]];

  // Next pointers and storage
  always_comb begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    if (clr) begin
      wr_d = '0;
      rd_d = '0;
    end else begin
      if (in_valid && !full) begin
        mem_d[wr_q[AW-1:0]] = in_data;
        wr_d = wr_q + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_d = rd_q + 1'b1;
      end
    end
  end

  // Register only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
    end else if (ce) begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      mem_q <= mem_d;
    end
  end
endmodule : sef_fifo
`default_nettype wire

// File: hw/sef_sync.sv
/*
  Three-stage synchroniser with agreement filter for pin inputs.
  Assumes the input is asynchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module sef_sync #(
  parameter logic INIT = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic pin,
  output logic level
);
  logic s1_q, s2_q, s3_q, lvl_q;
  logic lvl_d;
  // Change only once stages two and three agree
  always_comb begin
    lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
  end
  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      lvl_q <= INIT;
    end else if (ce) begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end
  assign level = lvl_q;
endmodule : sef_sync
`default_nettype wire

// File: testbench/sef_top_chk.sv
/*
  Pin-level checks for the serial EEPROM front end.
  Assumes the bind below and a shortened write cycle count.
*/
`timescale 1ns/1ps
`default_nettype none
module sef_top_chk #(
  parameter int TWC_CYCLES = 50
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic so_o,
  input wire logic so_oe,
  input wire logic write_in_progress_flag
);
  // Cycles the busy flag has stood so far
  int run_q;
  int run_d;
  // Grows while busy, clears otherwise
  always_comb run_d = write_in_progress_flag ? run_q + 1 : 0;
  // Count register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n)
      run_q <= 0;
    else
      run_q <= run_d;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  chk_oe_deselect: assert property (
    cs_n [*8] |-> !so_oe) else $error("so driven while deselected");
  chk_oe_paused: assert property (
    (!hold_n) [*8] |-> !so_oe) else $error("so driven while paused");
  chk_oe_rise_active: assert property (
    $rose(so_oe) |-> !cs_n && hold_n) else $error("so enabled when idle");
  chk_oe_fall_cause: assert property (
    $fell(so_oe) |-> cs_n || !hold_n) else $error("so dropped in frame");
  chk_so_pause_still: assert property (
    (!hold_n) [*8] ##1 !hold_n |-> $stable(so_o))
    else $error("so moved while paused");
  chk_busy_after_sel: assert property (
    $rose(write_in_progress_flag) |-> cs_n && $past(cs_n, 3))
    else $error("busy rose inside a frame");
  chk_busy_max: assert property (
    write_in_progress_flag |-> run_q < TWC_CYCLES + 2)
    else $error("busy stood too long");
  chk_busy_length: assert property (
    $fell(write_in_progress_flag) |->
      run_q >= TWC_CYCLES - 1 && run_q <= TWC_CYCLES + 1)
    else $error("busy length off");
endmodule : sef_top_chk
bind sef_top sef_top_chk #(.TWC_CYCLES(TWC_CYCLES)) u_chk (
  .ref_clk(ref_clk), .arst_n(arst_n), .cs_n(cs_n), .hold_n(hold_n),
  .so_o(so_o), .so_oe(so_oe),
  .write_in_progress_flag(write_in_progress_flag));
`default_nettype wire

// File: testbench/sef_host.sv
/*
  SPI host model: frames, MSB-first shifting and pauses.
  Assumes a 40 MHz ref_clk; sck period is 8 cycles (200 ns).
*/
`timescale 1ns/1ps
`default_nettype none
module sef_host (
  input wire logic ref_clk,
  input wire logic so_w,
  output logic sck,
  output logic cs_n,
  output logic hold_n,
  output logic si
);
  // Idle: deselected, running, clock parked low
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    hold_n = 1'b1;
    si = 1'b0;
  end
  // Wait n reference cycles
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  // Frame edge, only with the clock parked low
  task automatic sel(input logic v);
    tick(4);
    cs_n <= v;
    si <= ~si; // Released data never keeps its last level
    tick(8);
  endtask : sel
  // Shift n bits; so is taken late in the high phase
  task automatic xfer(input logic [7:0] tx, input int n,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      si <= tx[i];
      tick(4);
      sck <= 1'b1;
      tick(3);
      rx = {rx[6:0], so_w};
      tick(1);
      sck <= 1'b0;
    end
  endtask : xfer
  // Pause with the shared clock and data still toggling
  task automatic hold(input logic run);
    hold_n <= run;
    if (!run) begin
      repeat (8) begin
        tick(4);
        sck <= ~sck;
        si <= ~si;
      end
    end
    tick(8);
  endtask : hold
endmodule : sef_host
`default_nettype wire

// File: testbench/testbench.sv
/*
  Self-checking bench: random writes, reads, pauses, aborts, status.
  Assumes sef_host on the pins and the checker bound to the DUT.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1; // Freezes the DUT while low
  logic sck, cs_n, hold_n, si, so_o, so_oe, wr_busy;
  logic so_w;
  int err_total = 0;
  int checks_done = 0;
  logic [15:0] seed_q = 16'hFF15; // Fixed LFSR start
  logic [7:0] mem_m [1024]; // Expected array
  logic [7:0] buf_m [8];
  logic [7:0] rx;
  always #12.5 ref_clk = ~ref_clk; // 40 MHz
  assign so_w = so_oe ? so_o : 1'b1; // Pull-up on released line
  sef_top #(.TWC_CYCLES(50)) DUT (
    .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .sck(sck),
    .cs_n(cs_n), .hold_n(hold_n), .si(si), .so_o(so_o), .so_oe(so_oe),
    .write_in_progress_flag(wr_busy));
  sef_host host (.ref_clk(ref_clk), .so_w(so_w), .sck(sck), .cs_n(cs_n),
    .hold_n(hold_n), .si(si));
  // Next LFSR byte
  function automatic logic [7:0] rnd8();
    seed_q = {seed_q[14:0], seed_q[15] ^ seed_q[13] ^ seed_q[12] ^ seed_q[10]};
    return seed_q[7:0];
  endfunction : rnd8
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk8
  // Bounded wait for the busy level
  task automatic wait_busy(input logic lvl);
    int n = 0;
    while (wr_busy !== lvl && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    chk8({7'h00, wr_busy}, {7'h00, lvl});
    if (n == 400)
      complete_run();
  endtask : wait_busy
  // One-byte command frame
  task automatic op(input logic [7:0] code);
    host.sel(1'b0);
    host.xfer(code, 8, rx);
    host.sel(1'b1);
  endtask : op
  task automatic stat(input logic [7:0] mask, input logic [7:0] exp);
    host.sel(1'b0);
    host.xfer(8'h05, 8, rx);
    host.xfer(8'h00, 8, rx);
    host.sel(1'b1);
    chk8(rx & mask, exp);
  endtask : stat
  // Write n bytes; cut ends the frame inside the last byte
  task automatic wr(input logic [15:0] a, input int n, input bit en,
                    input bit cut);
    if (en)
      op(8'h06);
    host.sel(1'b0);
    host.xfer(8'h02, 8, rx);
    host.xfer(a[15:8], 8, rx);
    host.xfer(a[7:0], 8, rx);
    for (int i = 0; i < n; i++) begin
      buf_m[i] = rnd8();
      host.xfer(buf_m[i], (cut && i == n - 1) ? 4 : 8, rx);
    end
    host.sel(1'b1);
    if (!en || cut) begin
      repeat (20) @(posedge ref_clk);
      chk8({7'h00, wr_busy}, 8'h00);
    end else begin
      wait_busy(1'b1);
      wait_busy(1'b0);
      for (int i = 0; i < n; i++)
        mem_m[10'(a + i)] = buf_m[i];
    end
  endtask : wr
  // Read n bytes; hp pauses inside the first byte
  task automatic rd(input logic [15:0] a, input int n, input bit hp);
    logic [7:0] hi;
    host.sel(1'b0);
    host.xfer(8'h03, 8, rx);
    host.xfer(a[15:8], 8, rx);
    host.xfer(a[7:0], 8, rx);
    for (int i = 0; i < n; i++) begin
      if (hp && i == 0) begin
        host.xfer(8'h00, 3, hi);
        host.hold(1'b0);
        chk8({7'h00, so_oe}, 8'h00);
        host.hold(1'b1);
        host.xfer(8'h00, 5, rx);
        rx = {hi[2:0], rx[4:0]};
      end else
        host.xfer(8'h00, 8, rx);
      chk8(rx, mem_m[10'(a + i)]);
    end
    host.sel(1'b1);
  endtask : rd
  // Main sequence
  initial begin
    logic [15:0] a;
    logic [7:0] v;
    foreach (mem_m[i]) mem_m[i] = 8'h00;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (10) @(posedge ref_clk);
    stat(8'h03, 8'h00);
    op(8'h06);
    stat(8'h03, 8'h02);
    op(8'h04);
    stat(8'h03, 8'h00);
    wr(16'h0010, 2, 1'b0, 1'b0);
    rd(16'h0010, 2, 1'b0);
    $display("test latch and status done");
    for (int k = 0; k < 8; k++) begin
      v = rnd8();
      a = {rnd8(), v & 8'hF8};
      wr(a, 1 + v[2:0], 1'b1, k == 3);
      host.sel(1'b0);
      host.xfer(rnd8(), 5, rx);
      host.sel(1'b1);
      rd(a ^ 16'hFC00, 8, k[0]);
      $display("test round %0d done", k);
    end
    op(8'h06);
    v = rnd8();
    host.sel(1'b0);
    host.xfer(8'h01, 8, rx);
    host.xfer(v, 8, rx);
    host.sel(1'b1);
    wait_busy(1'b0);
    stat(8'hFC, v & 8'hFC);
    $display("test status write done");
    // Frozen block must not see a latch-set frame
    clk_en <= 1'b0;
    op(8'h06);
    clk_en <= 1'b1;
    stat(8'h03, 8'h00);
    op(8'h06);
    stat(8'h03, 8'h02);
    $display("test freeze done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
